// file: pcc_top.sv
/*
  cascaded pair of 8-input interrupt controllers: command words, request
  capture, rotation, polling, masking and the two-pulse acknowledge.
  assumes a single 10 mhz clock, synchronous inputs, and a host that
  issues one-cycle read/write strobes and acknowledge pulses.
*/
// Behaviour
// - automatic rotation makes serviced level lowest, on the master only (the slave never ends automatically)
// - rotate on non-specific eoi
// - rotate-in-auto-eoi set and cleared
// - set-priority makes coded level bottom
// - set-priority keeps service; specific rotate clears
// - poll read acknowledges and returns level
// - requests frozen between poll write and read
// - master plus slave give fifteen levels
// - cascade code 010b selects slave
// - slave supplies vector on second pulse
// - legacy trigger bit ignored; per-input trigger register
// - inputs 0,1,2,8,13 fixed edge
// - edge mode needs low-to-high transition
// - level mode follows high level
// - dropped request yields default level seven
// - default level seven leaves service clear
// - each mask bit blocks its input
// - master mask bit 2 blocks slave
// - service bit blocks lower priorities
// - special mask ignores service bits
// - special mask entered and left
// - non-specific eoi clears highest service bit
// - after init input 0 highest
// - slave matches cascade code with id
// - vector upper bits from base word
`timescale 1ns/1ps
`default_nettype none
`include "pcc_map.svh"

module pcc_top
  import pcc_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic [15:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic [15:0] irq_in,
  input  wire logic        interrupt_ack_strobe,
  output logic             cpu_interrupt_request,
  output logic      [7:0]  ack_vector,
  output logic             ack_vector_valid,
  output logic      [2:0]  cascade_code,
  output logic             cascade_valid
);

  // ----------------------------------------------------------------------
  // shared signals
  // ----------------------------------------------------------------------
  logic       any_w      [2];
  logic [2:0] win_w      [2];
  logic [4:0] vbase_ff   [2];
  logic [2:0] casid_ff   [2];
  logic [7:0] rd_val_w   [2];
  logic       rd_hit_w   [2];
  logic [7:0] raw_w      [2];
  logic [7:0] trig_ff    [2];
  logic       auto_end_of_interrupt_ff    [2];

  pcc_ack_t   ack_ff;
  logic       ack1;
  logic       ack2;
  logic       cas_hit;
  logic       slave_sel_ff;
  logic [2:0] resp_lvl_ff;
  logic [7:0] vec_ff;
  logic       vec_vld_ff;
  logic [2:0] cas_code_ff;
  logic       cas_vld_ff;
  logic       cpu_int_ff;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;

  assign ack1 = interrupt_ack_strobe && (ack_ff == PCC_ACK_IDLE);
  assign ack2 = interrupt_ack_strobe && (ack_ff == PCC_ACK_WAIT2);

  assign cas_hit = any_w[0] && (win_w[0] == `PCC_CASCADE_LEVEL)
                   && (win_w[0] == casid_ff[1]);

  // slave output feeds master input 2
  assign raw_w[0] = {irq_in[7:3], any_w[1], irq_in[1:0]};
  assign raw_w[1] = {irq_in[15:9], ~irq_in[8]};

  // ----------------------------------------------------------------------
  // per-controller logic
  // ----------------------------------------------------------------------
  for (genvar c = 0; c < 2; c++)
  begin : g_ctl
    localparam logic [15:0] BASE  = (c == 0) ? `PCC_MASTER_BASE : `PCC_SLAVE_BASE;
    localparam logic [15:0] TADDR = (c == 0) ? `PCC_TRIG_MASTER_ADDR
                                             : `PCC_TRIG_SLAVE_ADDR;
    localparam logic [7:0]  FIXED = (c == 0) ? `PCC_TRIG_FIXED_M : `PCC_TRIG_FIXED_S;

    pcc_init_t  init_ff;
    logic [7:0] imr_ff;
    logic [7:0] isr_ff;
    logic [7:0] irr_ff;
    logic [7:0] prev_ff;
    logic [2:0] lowest_ff;
    logic       rot_auto_end_of_interrupt_ff;
    logic       smm_ff;
    logic       poll_ff;
    logic       ris_ff;
    logic       isr_any;
    logic [2:0] isr_top;
    logic       wr_cmd;
    logic       wr_dat;
    logic       init1;
    logic       rotate_eoi_command_word;
    logic       status_select_command_word;
    logic       poll_rd;
    logic       take;
    logic       auto_eoi;
    logic [2:0] lvl_code;
    logic [7:0] set_v;
    logic [7:0] clr_v;
    logic [7:0] nxt_irr;

    assign wr_cmd   = reg_wr && (reg_addr == BASE);
    assign wr_dat   = reg_wr && (reg_addr == BASE + 16'h0001);
    assign init1    = wr_cmd && reg_wdata[`PCC_INIT_SEL_BIT];
    assign rotate_eoi_command_word     = wr_cmd && !reg_wdata[`PCC_INIT_SEL_BIT]
                      && !reg_wdata[`PCC_STAT_SEL_BIT];
    assign status_select_command_word     = wr_cmd && !reg_wdata[`PCC_INIT_SEL_BIT]
                      && reg_wdata[`PCC_STAT_SEL_BIT];
    assign poll_rd  = reg_rd && (reg_addr == BASE) && poll_ff;
    assign take     = (c == 0) ? 1'b1 : cas_hit;
    assign auto_eoi = (c == 0) && ack2 && auto_end_of_interrupt_ff[c] && isr_any;
    assign lvl_code = reg_wdata[2:0];

    pcc_prio #(
      .LEVELS (8)
    ) u_prio (
      .req     (irr_ff),
      .in_service_register     (isr_ff),
      .mask    (imr_ff),
      .lowest  (lowest_ff),
      .special_mask_bit     (smm_ff),
      .any     (any_w[c]),
      .win     (win_w[c]),
      .isr_any (isr_any),
      .isr_top (isr_top)
    );

    // initialisation sequence and configuration words
    // legacy trigger bit ignored
    always_ff @(posedge mclk)
    begin
      if (reset)
      begin
        init_ff     <= PCC_INIT_DONE;
        imr_ff      <= `PCC_MASK_RST;
        vbase_ff[c] <= 5'h00;
        casid_ff[c] <= 3'h0;
        auto_end_of_interrupt_ff[c]  <= 1'b0;
      end
      else if (init1)
      begin
        init_ff <= PCC_INIT_W2;
        imr_ff  <= `PCC_MASK_RST;
      end
      else if (wr_dat)
      begin
        unique case (init_ff)
          PCC_INIT_W2: begin vbase_ff[c] <= reg_wdata[7:3]; init_ff <= PCC_INIT_W3; end
          PCC_INIT_W3: begin casid_ff[c] <= reg_wdata[2:0]; init_ff <= PCC_INIT_W4; end
          PCC_INIT_W4: begin auto_end_of_interrupt_ff[c] <= reg_wdata[`PCC_AUTO_END_OF_INTERRUPT_BIT]; init_ff <= PCC_INIT_DONE; end
          PCC_INIT_DONE: imr_ff <= reg_wdata;
        endcase
      end
    end

    // status-select command word: special mask, poll, read select
    always_ff @(posedge mclk)
    begin
      if (reset || init1)
      begin
        smm_ff  <= 1'b0;
        poll_ff <= 1'b0;
        ris_ff  <= 1'b0;
      end
      else if (status_select_command_word)
      begin
        if (reg_wdata[`PCC_SMM_WE_BIT])
        begin
          smm_ff <= reg_wdata[`PCC_SMM_BIT];
        end
        if (reg_wdata[`PCC_RR_BIT])
        begin
          ris_ff <= reg_wdata[`PCC_RIS_BIT];
        end
        poll_ff <= reg_wdata[`PCC_POLL_BIT];
      end
      else if (poll_rd)
      begin
        poll_ff <= 1'b0;
      end
    end

    // trigger mode register
    always_ff @(posedge mclk)
    begin
      if (reset)
      begin
        trig_ff[c] <= `PCC_TRIG_RST;
      end
      else if (reg_wr && reg_addr == TADDR)
      begin
        trig_ff[c] <= reg_wdata & ~FIXED;
      end
    end

    // in-service set and clear sources
    always_comb
    begin
      set_v = 8'h00;
      clr_v = 8'h00;
      if ((ack1 && take && any_w[c]) || (poll_rd && any_w[c]))
      begin
        set_v[win_w[c]] = 1'b1;
      end
      if (rotate_eoi_command_word && reg_wdata[`PCC_EOI_BIT])
      begin
        if (reg_wdata[`PCC_SEL_LVL_BIT])
        begin
          clr_v[lvl_code] = 1'b1;
        end
        else if (isr_any)
        begin
          clr_v[isr_top] = 1'b1;
        end
      end
      if (auto_eoi)
      begin
        clr_v[isr_top] = 1'b1;
      end
    end

    always_ff @(posedge mclk)
    begin
      if (reset || init1)
      begin
        isr_ff <= 8'h00;
      end
      else
      begin
        isr_ff <= (isr_ff & ~clr_v) | set_v;
      end
    end

    // request capture, frozen while a poll is outstanding
    always_comb
    begin
      nxt_irr = irr_ff;
      if (!poll_ff)
      begin
        nxt_irr = raw_w[c] & (trig_ff[c] | irr_ff | ~prev_ff);
      end
      nxt_irr = nxt_irr & ~set_v;
    end

    always_ff @(posedge mclk)
    begin
      if (reset)
      begin
        irr_ff  <= 8'h00;
        prev_ff <= 8'h00;
      end
      else
      begin
        irr_ff <= nxt_irr;
        if (!poll_ff)
        begin
          prev_ff <= raw_w[c];
        end
      end
    end

    // priority rotation
    always_ff @(posedge mclk)
    begin
      if (reset || init1)
      begin
        lowest_ff   <= `PCC_LOWEST_RST;
        rot_auto_end_of_interrupt_ff <= 1'b0;
      end
      else if (rotate_eoi_command_word)
      begin
        if (reg_wdata[`PCC_ROT_BIT] && reg_wdata[`PCC_SEL_LVL_BIT])
        begin
          lowest_ff <= lvl_code;
        end
        else if (reg_wdata[`PCC_ROT_BIT] && reg_wdata[`PCC_EOI_BIT] && isr_any)
        begin
          lowest_ff <= isr_top;
        end
        else if (!reg_wdata[`PCC_EOI_BIT] && !reg_wdata[`PCC_SEL_LVL_BIT])
        begin
          rot_auto_end_of_interrupt_ff <= reg_wdata[`PCC_ROT_BIT];
        end
      end
      else if (auto_eoi && rot_auto_end_of_interrupt_ff)
      begin
        lowest_ff <= isr_top;
      end
    end

    // read selection
    always_comb
    begin
      rd_hit_w[c] = 1'b1;
      rd_val_w[c] = `PCC_UNMAPPED_READ;
      if (reg_addr == BASE && poll_ff)
      begin
        rd_val_w[c] = {any_w[c], 4'h0, win_w[c]};
      end
      else if (reg_addr == BASE)
      begin
        rd_val_w[c] = ris_ff ? isr_ff : irr_ff;
      end
      else if (reg_addr == BASE + 16'h0001)
      begin
        rd_val_w[c] = imr_ff;
      end
      else if (reg_addr == TADDR)
      begin
        rd_val_w[c] = trig_ff[c];
      end
      else
      begin
        rd_hit_w[c] = 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // acknowledge sequence
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      ack_ff <= PCC_ACK_IDLE;
    end
    else if (ack1)
    begin
      ack_ff <= PCC_ACK_WAIT2;
    end
    else if (ack2)
    begin
      ack_ff <= PCC_ACK_IDLE;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      slave_sel_ff <= 1'b0;
      resp_lvl_ff  <= 3'h0;
      cas_code_ff  <= 3'h0;
      cas_vld_ff   <= 1'b0;
    end
    else if (ack1)
    begin
      slave_sel_ff <= cas_hit;
      cas_code_ff  <= cas_hit ? win_w[0] : 3'h0;
      cas_vld_ff   <= cas_hit;
      if (cas_hit)
      begin
        resp_lvl_ff <= any_w[1] ? win_w[1] : `PCC_DEFAULT_LEVEL;
      end
      else
      begin
        resp_lvl_ff <= any_w[0] ? win_w[0] : `PCC_DEFAULT_LEVEL;
      end
    end
    else if (ack2)
    begin
      // code returns to idle together with the select
      cas_code_ff <= 3'h0;
      cas_vld_ff  <= 1'b0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      vec_ff     <= 8'h00;
      vec_vld_ff <= 1'b0;
    end
    else
    begin
      vec_vld_ff <= ack2;
      if (ack2)
      begin
        vec_ff <= {slave_sel_ff ? vbase_ff[1] : vbase_ff[0], resp_lvl_ff};
      end
    end
  end

  // ----------------------------------------------------------------------
  // processor request and register read port
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      cpu_int_ff <= 1'b0;
    end
    else
    begin
      cpu_int_ff <= any_w[0];
    end
  end

  always_comb
  begin
    nxt_rdata = `PCC_UNMAPPED_READ;
    if (rd_hit_w[0])
    begin
      nxt_rdata = rd_val_w[0];
    end
    else if (rd_hit_w[1])
    begin
      nxt_rdata = rd_val_w[1];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      rdata_ff <= 8'h00;
    end
    else if (reg_rd)
    begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata             = rdata_ff;
  assign cpu_interrupt_request = cpu_int_ff;
  assign ack_vector            = vec_ff;
  assign ack_vector_valid      = vec_vld_ff;
  assign cascade_code          = cas_code_ff;
  assign cascade_valid         = cas_vld_ff;

endmodule // pcc_top

`default_nettype wire

// file: pcc_map.svh
/*
  register addresses, command-word bit positions and reset values of the
  cascaded interrupt controller pair.
  assumes a 16-bit i/o address and 8-bit data on the register port.
*/
`ifndef PCC_MAP_SVH
`define PCC_MAP_SVH

// ----------------------------------------------------------------------
// i/o addresses
// ----------------------------------------------------------------------
`define PCC_MASTER_BASE      16'h0020
`define PCC_SLAVE_BASE       16'h00A0
`define PCC_TRIG_MASTER_ADDR 16'h00E0
`define PCC_TRIG_SLAVE_ADDR  16'h00E1

// ----------------------------------------------------------------------
// command word bits
// ----------------------------------------------------------------------
`define PCC_INIT_SEL_BIT     4
`define PCC_STAT_SEL_BIT     3
`define PCC_LEGACY_LEGACY_LEVEL_TRIGGER_BIT_BIT  3
`define PCC_ROT_BIT          7
`define PCC_SEL_LVL_BIT      6
`define PCC_EOI_BIT          5
`define PCC_SMM_WE_BIT       6
`define PCC_SMM_BIT          5
`define PCC_POLL_BIT         2
`define PCC_RR_BIT           1
`define PCC_RIS_BIT          0
`define PCC_AUTO_END_OF_INTERRUPT_BIT         1

// ----------------------------------------------------------------------
// fixed codes and reset values
// ----------------------------------------------------------------------
`define PCC_CASCADE_LEVEL    3'h2
`define PCC_DEFAULT_LEVEL    3'h7
`define PCC_LOWEST_RST       3'h7
`define PCC_MASK_RST         8'h00
`define PCC_TRIG_RST         8'h00
`define PCC_TRIG_FIXED_M     8'h07
`define PCC_TRIG_FIXED_S     8'h21
`define PCC_UNMAPPED_READ    8'h00

`endif

// file: pcc_pkg.sv
/*
  types shared by the cascaded interrupt controller files.
  assumes nothing beyond a systemverilog compiler.
*/
package pcc_pkg;

  typedef enum logic [1:0] {
    PCC_ACK_IDLE  = 2'b01,
    PCC_ACK_WAIT2 = 2'b10
  } pcc_ack_t;

  typedef enum logic [3:0] {
    PCC_INIT_DONE = 4'b0001,
    PCC_INIT_W2   = 4'b0010,
    PCC_INIT_W3   = 4'b0100,
    PCC_INIT_W4   = 4'b1000
  } pcc_init_t;

endpackage

// file: pcc_prio.sv
/*
  priority resolver of one 8-input controller: rotating priority,
  in-service blocking, masking and the end-of-interrupt target.
  assumes all inputs are registered state of the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none

module pcc_prio
  import pcc_pkg::*;
#(
  parameter int LEVELS = 8
)
(
  input  wire logic [LEVELS-1:0]         req,
  input  wire logic [LEVELS-1:0]         in_service_register,
  input  wire logic [LEVELS-1:0]         mask,
  input  wire logic [$clog2(LEVELS)-1:0] lowest,
  input  wire logic                      special_mask_bit,
  output logic                           any,
  output logic [$clog2(LEVELS)-1:0]      win,
  output logic                           isr_any,
  output logic [$clog2(LEVELS)-1:0]      isr_top
);

  localparam int LW = $clog2(LEVELS);

  if (LEVELS < 2 || (1 << LW) != LEVELS)
  begin : g_chk
    $error("pcc_prio: LEVELS must be a power of two");
  end

  always_comb
  begin
    logic              blocked;
    logic [LW-1:0]     lvl;
    blocked = 1'b0;
    lvl     = '0;
    any     = 1'b0;
    win     = '0;
    isr_any = 1'b0;
    isr_top = '0;
    // scan from the level just above the bottom one, circularly
    for (int j = 0; j < LEVELS; j++)
    begin
      lvl = lowest + LW'(j + 1);
      if (in_service_register[lvl] && !special_mask_bit)
      begin
        blocked = 1'b1;
      end
      if (!any && !blocked && req[lvl] && !mask[lvl])
      begin
        any = 1'b1;
        win = lvl;
      end
      if (!isr_any && in_service_register[lvl] && !(special_mask_bit && mask[lvl]))
      begin
        isr_any = 1'b1;
        isr_top = lvl;
      end
    end
  end

endmodule // pcc_prio

`default_nettype wire

// file: pcc_checker.sv
/*
  concurrent checks on the ports of the cascaded controller pair.
  assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none

module pcc_checker
  import pcc_pkg::*;
(
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic        interrupt_ack_strobe,
  input wire logic        cpu_interrupt_request,
  input wire logic        ack_vector_valid,
  input wire logic [2:0]  cascade_code,
  input wire logic        cascade_valid
);
  // high between first and second acknowledge pulse
  logic second_ff;

  always_ff @(posedge mclk)
  begin
    if (reset)
      second_ff <= 1'b0;
    else if (interrupt_ack_strobe)
      second_ff <= ~second_ff;
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  sequence s_first_pulse;
    interrupt_ack_strobe && !second_ff;
  endsequence
  sequence s_second_pulse;
    interrupt_ack_strobe && second_ff;
  endsequence

  property p_vec_after_second;
    s_second_pulse |=> ack_vector_valid;
  endproperty
  a_vec_after_second: assert property (p_vec_after_second)
    else $error("no vector after second pulse");
  property p_vec_one_cycle;
    ack_vector_valid |=> !ack_vector_valid;
  endproperty
  a_vec_one_cycle: assert property (p_vec_one_cycle)
    else $error("vector valid longer than one cycle");
  property p_casc_code;
    cascade_valid |-> cascade_code == 3'h2;
  endproperty
  a_casc_code: assert property (p_casc_code)
    else $error("slave select without code 010");
  property p_casc_idle;
    !cascade_valid |-> cascade_code == 3'h0;
  endproperty
  a_casc_idle: assert property (p_casc_idle)
    else $error("cascade code without slave select");
  property p_casc_start;
    $rose(cascade_valid) |-> $past(interrupt_ack_strobe) && second_ff;
  endproperty
  a_casc_start: assert property (p_casc_start)
    else $error("slave select not after first pulse");
  property p_reset_quiet;
    disable iff (1'b0) reset |=> !cpu_interrupt_request && !ack_vector_valid && !cascade_valid;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("outputs active after reset");
  property p_trig_fixed_m;
    reg_rd && reg_addr == 16'h00E0 |=> reg_rdata[2:0] == 3'h0;
  endproperty
  a_trig_fixed_m: assert property (p_trig_fixed_m)
    else $error("master fixed trigger bits set");
  property p_trig_fixed_s;
    reg_rd && reg_addr == 16'h00E1 |=> !reg_rdata[0] && !reg_rdata[5];
  endproperty
  a_trig_fixed_s: assert property (p_trig_fixed_s)
    else $error("slave fixed trigger bits set");
  property p_mask_all;
    reg_wr && reg_addr == 16'h0021 && reg_wdata == 8'hFF |-> ##2 !cpu_interrupt_request [*2];
  endproperty
  a_mask_all: assert property (p_mask_all)
    else $error("request while all inputs masked");
endmodule // pcc_checker

bind pcc_top pcc_checker u_chk (
  .mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .interrupt_ack_strobe(interrupt_ack_strobe),
  .cpu_interrupt_request(cpu_interrupt_request), .ack_vector_valid(ack_vector_valid),
  .cascade_code(cascade_code), .cascade_valid(cascade_valid)
);

`default_nettype wire

// file: pcc_host_model.sv
/*
  host model: one-cycle register strobes and two-pulse acknowledges.
  assumes reads answer in the cycle after the strobe.
*/
`timescale 1ns/1ps
`default_nettype none

module pcc_host_model
(
  input  wire logic        mclk,
  input  wire logic [7:0]  reg_rdata,
  input  wire logic [7:0]  ack_vector,
  input  wire logic [2:0]  cascade_code,
  output var  logic [15:0] reg_addr,
  output var  logic [7:0]  reg_wdata,
  output var  logic        reg_wr,
  output var  logic        reg_rd,
  output var  logic        interrupt_ack_strobe
);
  initial
  begin
    reg_addr = 16'h0000;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    interrupt_ack_strobe = 1'b0;
  end

  // released data bus shows the inverse of the last value
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic ack2(output logic [7:0] v, output logic [2:0] cc);
    @(posedge mclk);
    interrupt_ack_strobe <= 1'b1;
    @(posedge mclk);
    interrupt_ack_strobe <= 1'b0;
    #1;
    cc = cascade_code;
    @(posedge mclk);
    interrupt_ack_strobe <= 1'b1;
    @(posedge mclk);
    interrupt_ack_strobe <= 1'b0;
    #1;
    v = ack_vector;
  endtask
endmodule // pcc_host_model

`default_nettype wire

// file: tb_top.sv
/*
  self-checking bench for the cascaded controller pair.
  assumes design, checker and host model are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  localparam logic [7:0] MB = 8'h08;
  localparam logic [7:0] SB = 8'h70;
  localparam int WD_CYC = 5000;
  logic        mclk = 1'b0;
  logic        reset = 1'b1;
  logic [15:0] irq_in = 16'h0100;
  logic [15:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, ack_vector;
  logic [7:0]  lf = 8'h1F;
  logic        reg_wr, reg_rd, interrupt_ack_strobe, cpu_interrupt_request;
  logic        ack_vector_valid, cascade_valid;
  logic [2:0]  cascade_code;
  int          n_mismatch = 0;
  int          n_tests = 0;

  always #50 mclk = ~mclk;

  pcc_top DUT (.mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_in(irq_in),
    .interrupt_ack_strobe(interrupt_ack_strobe), .cpu_interrupt_request(cpu_interrupt_request),
    .ack_vector(ack_vector), .ack_vector_valid(ack_vector_valid),
    .cascade_code(cascade_code), .cascade_valid(cascade_valid));
  pcc_host_model host (.mclk(mclk), .reg_rdata(reg_rdata), .ack_vector(ack_vector),
    .cascade_code(cascade_code), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .interrupt_ack_strobe(interrupt_ack_strobe));

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [7:0] vec(input logic [7:0] b, input int l);
    return {b[7:3], 3'(l)};
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic irq(input logic [15:0] v);
    @(posedge mclk);
    irq_in <= v;
    cyc(3);
  endtask
  task automatic w(input logic [15:0] a, input logic [7:0] d);
    host.wr(a, d);
  endtask
  task automatic r(input logic [15:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd(a, d);
    chk(d, e);
  endtask
  task automatic ack(input logic [7:0] e, input logic [2:0] ec);
    logic [7:0] v;
    logic [2:0] c;
    host.ack2(v, c);
    chk(v, e);
    chk({5'h00, c}, {5'h00, ec});
  endtask
  task automatic req(input logic e);
    cyc(3);
    chk({7'h00, cpu_interrupt_request}, {7'h00, e});
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    repeat (WD_CYC) @(posedge mclk);
    n_mismatch++;
    tally_and_finish;
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    cyc(1);
    r(16'h0021, 8'h00);
    r(16'h00E0, 8'h00);
    r(16'h0300, 8'h00);
    // legacy level bit set, must be ignored
    w(16'h0020, 8'h19);
    w(16'h0021, MB);
    w(16'h0021, 8'h04);
    w(16'h0021, 8'h01);
    w(16'h00A0, 8'h11);
    w(16'h00A1, SB);
    w(16'h00A1, 8'h02);
    w(16'h00A1, 8'h01);
    irq(16'h0128);
    ack(vec(MB, 3), 3'h0);
    req(1'b0);
    w(16'h0021, 8'h08);
    w(16'h0020, 8'h68);
    req(1'b1);
    w(16'h0020, 8'h48);
    req(1'b0);
    w(16'h0021, 8'h00);
    w(16'h0020, 8'h20);
    req(1'b1);
    ack(vec(MB, 5), 3'h0);
    w(16'h0020, 8'h20);
    w(16'h0020, 8'h0B);
    r(16'h0020, 8'h00);
    req(1'b0);
    irq(16'h0100);
    $display("test nested done");
    w(16'h0021, 8'h08);
    irq(16'h0108);
    req(1'b0);
    w(16'h0021, 8'h00);
    req(1'b1);
    ack(vec(MB, 3), 3'h0);
    w(16'h0020, 8'h20);
    irq(16'h0100);
    $display("test mask done");
    irq(16'h0140);
    w(16'h0020, 8'h0C);
    irq(16'h0142);
    r(16'h0020, 8'h86);
    w(16'h0020, 8'h0B);
    r(16'h0020, 8'h40);
    w(16'h0020, 8'h20);
    w(16'h0020, 8'h0C);
    r(16'h0020, 8'h81);
    w(16'h0020, 8'h20);
    irq(16'h0100);
    $display("test poll done");
    irq(16'h0110);
    irq(16'h0100);
    ack(vec(MB, 7), 3'h0);
    w(16'h0020, 8'h0B);
    r(16'h0020, 8'h00);
    $display("test spurious done");
    irq(16'h1000);
    w(16'h0021, 8'h04);
    req(1'b0);
    w(16'h0021, 8'h00);
    req(1'b1);
    ack(vec(SB, 0), 3'h2);
    // one end of interrupt to each controller
    w(16'h00A0, 8'h20);
    w(16'h0020, 8'h20);
    ack(vec(SB, 4), 3'h2);
    w(16'h00A0, 8'h20);
    w(16'h0020, 8'h20);
    irq(16'h0100);
    $display("test cascade done");
    w(16'h0020, 8'hC4);
    irq(16'h0148);
    ack(vec(MB, 6), 3'h0);
    w(16'h0020, 8'hC4);
    r(16'h0020, 8'h40);
    w(16'h0020, 8'hE6);
    r(16'h0020, 8'h00);
    ack(vec(MB, 3), 3'h0);
    w(16'h0020, 8'hA0);
    irq(16'h0100);
    irq(16'h0111);
    ack(vec(MB, 4), 3'h0);
    w(16'h0020, 8'hA0);
    ack(vec(MB, 0), 3'h0);
    w(16'h0020, 8'hA0);
    w(16'h0020, 8'hC7);
    irq(16'h0100);
    $display("test rotation done");
    w(16'h00E0, 8'hFF);
    r(16'h00E0, 8'hF8);
    w(16'h00E1, 8'hFF);
    r(16'h00E1, 8'hDE);
    irq(16'h0120);
    ack(vec(MB, 5), 3'h0);
    // source withdraws before the end of interrupt
    irq(16'h0100);
    w(16'h0020, 8'h20);
    req(1'b0);
    irq(16'h0120);
    ack(vec(MB, 5), 3'h0);
    w(16'h0020, 8'h20);
    req(1'b1);
    ack(vec(MB, 5), 3'h0);
    irq(16'h0100);
    w(16'h0020, 8'h20);
    $display("test level done");
    // master re-initialised with automatic end of interrupt
    w(16'h0020, 8'h11);
    w(16'h0021, MB);
    w(16'h0021, 8'h04);
    w(16'h0021, 8'h03);
    w(16'h0020, 8'h80);
    irq(16'h0118);
    ack(vec(MB, 3), 3'h0);
    ack(vec(MB, 4), 3'h0);
    w(16'h0020, 8'h00);
    ack(vec(MB, 3), 3'h0);
    ack(vec(MB, 3), 3'h0);
    irq(16'h0100);
    $display("test auto rotation done");
    w(16'h0021, 8'hFF);
    r(16'h0021, 8'hFF);
    w(16'h0021, 8'h00);
    for (int i = 0; i < 6; i++)
    begin
      lf = lfsr(lf);
      w(16'h00A1, lf);
      r(16'h00A1, lf);
    end
    $display("test masks done");
    tally_and_finish;
  end
endmodule // tb_top

`default_nettype wire
